// [hw/xdec_defines.vh]
// constants for the extended opcode decoder
// Summary of operation
// RULE1: add literal to chosen pointer, one cycle
// RULE2: add to third pointer, then return
// RULE3: call subroutine through working register
// RULE4: move indexed source to absolute destination
// RULE5: move indexed source to indexed destination
// RULE6: store literal at third pointer, decrement
// RULE7: subtract literal from chosen pointer
// RULE8: subtract from third pointer, then return
// RULE9: indexed address is pointer plus offset
// RULE10: decode only when extension bit set
// RULE11: pointer field 11 selects return form
`ifndef XDEC_DEFINES_VH
`define XDEC_DEFINES_VH
`define XDEC_OP_ADD 8'he8
`define XDEC_OP_SUB 8'he9
`define XDEC_OP_PUSH 8'hea
`define XDEC_OP_MOVS 8'heb
`define XDEC_CALL_VIA_WORD 16'h0014
`define XDEC_SECOND_TAG 4'hf
`define XDEC_RET_SEL 2'h3
`define XDEC_PTR_RESET 12'h000
`endif

// [hw/xdec_ptr_file.v]
// three file select pointers with a single write port
`timescale 1ns/1ps
`default_nettype none
`include "xdec_defines.vh"
module xdec_ptr_file (
  input wire sys_clk,
  input wire rst,
  input wire wr_en,
  input wire [1:0] wr_sel,
  input wire [11:0] wr_data,
  output wire [11:0] ptr0,
  output wire [11:0] ptr1,
  output wire [11:0] ptr2
);
  reg [11:0] ptr_reg [0:2];
  integer i;
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (i = 0; i < 3; i = i + 1)
        ptr_reg[i] <= `XDEC_PTR_RESET;
    end
    else if (wr_en && wr_sel != 2'h3)
      ptr_reg[wr_sel] <= wr_data;
  end
  assign ptr0 = ptr_reg[0];
  assign ptr1 = ptr_reg[1];
  assign ptr2 = ptr_reg[2];
endmodule
`default_nettype wire

// [hw/xdec_core.v]
// decode and execute of the eight extended pointer instructions
`timescale 1ns/1ps
`default_nettype none
`include "xdec_defines.vh"
module xdec_core (
  input wire sys_clk,
  input wire rst,
  input wire extension_enable_bit,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [7:0] working_register,
  output reg instr_taken,
  output reg illegal_instr,
  output reg ret_req,
  output reg call_req,
  output reg [7:0] call_target,
  output reg mem_wr,
  output reg mem_rd,
  output reg [11:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg [11:0] move_src_addr,
  output reg [11:0] third_pointer_out,
  output reg busy
);
  // fetch waits for words, second waits for the move tail, wait is the dead slot
  localparam [1:0] ST_FETCH = 2'h0;
  localparam [1:0] ST_SECOND = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg indexed_dst_reg;
  reg indexed_dst_next;
  reg ptr_we;
  reg [1:0] ptr_sel;
  reg [11:0] ptr_wdata;
  reg t_taken;
  reg t_ill;
  reg t_ret;
  reg t_call;
  reg t_wr;
  reg t_rd;
  reg t_busy;
  reg [11:0] t_addr;
  reg [11:0] t_src;
  reg [7:0] t_wdata;
  reg [11:0] sel_ptr;
  wire [11:0] ptr0;
  wire [11:0] ptr1;
  wire [11:0] ptr2;
  wire [7:0] op_hi;
  wire [1:0] fsel;
  wire [11:0] lit6;

  assign op_hi = instr_word[15:8];
  assign fsel = instr_word[7:6];
  assign lit6 = {6'h00, instr_word[5:0]};

  xdec_ptr_file u_ptrs (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(ptr_we),
    .wr_sel(ptr_sel),
    .wr_data(ptr_wdata),
    .ptr0(ptr0),
    .ptr1(ptr1),
    .ptr2(ptr2)
  );

  always @*
  begin
    case (fsel)
      2'h0: sel_ptr = ptr0;
      2'h1: sel_ptr = ptr1;
      default: sel_ptr = ptr2;
    endcase
  end

  always @*
  begin
    state_next = state_reg;
    indexed_dst_next = indexed_dst_reg;
    ptr_we = 1'b0;
    ptr_sel = 2'h0;
    ptr_wdata = 12'h000;
    t_taken = 1'b0;
    t_ill = 1'b0;
    t_ret = 1'b0;
    t_call = 1'b0;
    t_wr = 1'b0;
    t_rd = 1'b0;
    t_busy = 1'b0;
    t_addr = 12'h000;
    t_src = move_src_addr;
    t_wdata = 8'h00;
    case (state_reg)
      ST_FETCH:
      begin
        if (instr_valid)
        begin
          if (!extension_enable_bit) // see RULE10
            t_ill = 1'b1;
          else if (op_hi == `XDEC_OP_ADD || op_hi == `XDEC_OP_SUB)
          begin
            t_taken = 1'b1;
            ptr_we = 1'b1;
            // return forms always adjust the third pointer
            ptr_sel = (fsel == `XDEC_RET_SEL) ? 2'h2 : fsel;
            if (op_hi == `XDEC_OP_ADD)
              ptr_wdata = sel_ptr + lit6; // see RULE1
            else
              ptr_wdata = sel_ptr - lit6; // see RULE7
            if (fsel == `XDEC_RET_SEL) // see RULE11
            begin
              t_ret = 1'b1; // see RULE2 see RULE8
              t_busy = 1'b1;
              state_next = ST_WAIT;
            end
          end
          else if (op_hi == `XDEC_OP_PUSH)
          begin
            t_taken = 1'b1;
            // store at the old pointer, then step it down
            t_wr = 1'b1; // see RULE6
            t_addr = ptr2;
            t_wdata = instr_word[7:0];
            ptr_we = 1'b1;
            ptr_sel = 2'h2;
            ptr_wdata = ptr2 - 12'h001;
          end
          else if (instr_word == `XDEC_CALL_VIA_WORD)
          begin
            t_taken = 1'b1;
            // target is latched from the working register
            t_call = 1'b1; // see RULE3
            t_busy = 1'b1;
            state_next = ST_WAIT;
          end
          else if (op_hi == `XDEC_OP_MOVS)
          begin
            t_taken = 1'b1;
            t_busy = 1'b1;
            indexed_dst_next = instr_word[7];
            // source is resolved now, destination with the tail word
            t_src = ptr2 + {5'h00, instr_word[6:0]}; // see RULE9
            t_rd = 1'b1;
            t_addr = t_src;
            state_next = ST_SECOND;
          end
          else
            t_ill = 1'b1;
        end
      end
      ST_SECOND:
      begin
        t_busy = 1'b1;
        if (instr_valid)
        begin
          t_busy = 1'b0;
          state_next = ST_FETCH;
          // a tail without the move tag aborts the move
          if (instr_word[15:12] != `XDEC_SECOND_TAG)
            t_ill = 1'b1;
          else
          begin
            t_taken = 1'b1;
            t_wr = 1'b1;
            if (indexed_dst_reg)
              t_addr = ptr2 + {5'h00, instr_word[6:0]}; // see RULE5 see RULE9
            else
              t_addr = instr_word[11:0]; // see RULE4
          end
        end
      end
      // words arriving in the slot after a return or call are dropped
      ST_WAIT:
        state_next = ST_FETCH;
      default:
        state_next = ST_FETCH;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_FETCH;
      indexed_dst_reg <= 1'b0;
      instr_taken <= 1'b0;
      illegal_instr <= 1'b0;
      ret_req <= 1'b0;
      call_req <= 1'b0;
      call_target <= 8'h00;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      mem_addr <= 12'h000;
      mem_wdata <= 8'h00;
      move_src_addr <= 12'h000;
      third_pointer_out <= `XDEC_PTR_RESET;
      busy <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      indexed_dst_reg <= indexed_dst_next;
      instr_taken <= t_taken;
      illegal_instr <= t_ill;
      ret_req <= t_ret;
      call_req <= t_call;
      call_target <= t_call ? working_register : call_target;
      mem_wr <= t_wr;
      mem_rd <= t_rd;
      mem_addr <= t_addr;
      mem_wdata <= t_wdata;
      move_src_addr <= t_src;
      // mirror of the third pointer after this cycle's update
      third_pointer_out <= (ptr_we && ptr_sel == 2'h2) ? ptr_wdata : ptr2;
      busy <= t_busy;
    end
  end
endmodule
`default_nettype wire

// [bench/xdec_props.sv]
// assertions on the extended decoder ports
`timescale 1ns/1ps
`default_nettype none
module xdec_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic extension_enable_bit,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] working_register,
  input wire logic instr_taken,
  input wire logic illegal_instr,
  input wire logic ret_req,
  input wire logic call_req,
  input wire logic [7:0] call_target,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [11:0] move_src_addr,
  input wire logic [11:0] third_pointer_out,
  input wire logic busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire go = instr_valid && !busy && extension_enable_bit;
  wire [7:0] h = instr_word[15:8];
  wire [1:0] f = instr_word[7:6];
  wire [11:0] p = third_pointer_out;
  property p_add;
    go && h == 8'he8 && f == 2'h0 |=> instr_taken && !illegal_instr && !busy && $stable(p);
  endproperty
  a_add: assert property (p_add) else $error("add");
  property p_ret; go && h[7:1] == 7'h74 && f == 2'h3 |=> ret_req && busy ##1 !busy;
  endproperty
  a_ret: assert property (p_ret) else $error("ret");
  property p_sub;
    go && h == 8'he9 && f == 2'h1 |=> instr_taken && !busy && !ret_req && !illegal_instr
      && $stable(p);
  endproperty
  a_sub: assert property (p_sub) else $error("sub");
  property p_call;
    go && instr_word == 16'h0014 |=> call_req && call_target == $past(working_register);
  endproperty
  a_call: assert property (p_call) else $error("call");
  property p_push;
    go && h == 8'hea |=> mem_wr && mem_wdata == $past(instr_word[7:0])
      && p == $past(p) - 12'h001;
  endproperty
  a_push: assert property (p_push) else $error("push");
  property p_movs;
    go && h == 8'heb |=> mem_rd && mem_addr == $past(p) + {5'h00, $past(instr_word[6:0])}
      && move_src_addr == mem_addr;
  endproperty
  a_movs: assert property (p_movs) else $error("move");
  property p_mv2;
    mem_rd && instr_valid && instr_word[15:12] == 4'hf |=> instr_taken && mem_wr && !busy
      && $stable(move_src_addr);
  endproperty
  a_mv2: assert property (p_mv2) else $error("move end");
  property p_bad;
    mem_rd && instr_valid && instr_word[15:12] != 4'hf |=> illegal_instr && !mem_wr
      && !instr_taken && !busy;
  endproperty
  a_bad: assert property (p_bad) else $error("bad move tail");
  property p_off; instr_valid && !busy && !extension_enable_bit |=> illegal_instr;
  endproperty
  a_off: assert property (p_off) else $error("off");
endmodule
bind xdec_core xdec_props u_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .extension_enable_bit(extension_enable_bit),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .working_register(working_register),
  .instr_taken(instr_taken),
  .illegal_instr(illegal_instr),
  .ret_req(ret_req),
  .call_req(call_req),
  .call_target(call_target),
  .mem_wr(mem_wr),
  .mem_rd(mem_rd),
  .mem_addr(mem_addr),
  .mem_wdata(mem_wdata),
  .move_src_addr(move_src_addr),
  .third_pointer_out(third_pointer_out),
  .busy(busy)
);
`default_nettype wire

// [bench/xdec_prog_mem.sv]
// program memory model handing out instruction words
`timescale 1ns/1ps
`default_nettype none
module xdec_prog_mem (
  input wire logic [2:0] sel,
  input wire logic [11:0] lit,
  output logic [15:0] word
);
  always_comb
    case (sel)
      3'h0: word = {8'hea, lit[7:0]};
      3'h1: word = {8'he8, 2'h3, lit[5:0]};
      3'h2: word = {8'he9, 2'h3, lit[5:0]};
      3'h3: word = 16'h0014;
      3'h4: word = {8'heb, lit[7:0]};
      3'h5: word = {4'hf, lit};
      3'h6: word = {7'h74, lit[11], 1'b0, lit[6], lit[5:0]};
      default: word = {8'he7, lit[7:0]};
    endcase
endmodule
`default_nettype wire

// [bench/xdec_core_tb.sv]
// bench for the extended decoder
`timescale 1ns/1ps
`default_nettype none
module xdec_core_tb;
  logic sys_clk = 0, rst = 1, extension_enable_bit = 0, instr_valid = 0;
  logic instr_taken, illegal_instr, ret_req, call_req, mem_wr, mem_rd, busy;
  logic [7:0] working_register = 8'h00, call_target, mem_wdata;
  logic [11:0] mem_addr, move_src_addr, third_pointer_out, lit = 12'h000, p2 = 12'h000;
  logic [15:0] instr_word;
  logic [2:0] sel = 3'h0, s;
  logic [5:0] ft [8] = '{6'h24, 6'h30, 6'h30, 6'h28, 6'h22, 6'h24, 6'h20, 6'h01};
  logic [17:0] q[$];
  logic [17:0] got;
  logic [31:0] r = 32'h9a928868;
  int failures = 0, n_compared = 0, cyc = 0;
  xdec_core u_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .extension_enable_bit(extension_enable_bit),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .working_register(working_register),
    .instr_taken(instr_taken),
    .illegal_instr(illegal_instr),
    .ret_req(ret_req),
    .call_req(call_req),
    .call_target(call_target),
    .mem_wr(mem_wr),
    .mem_rd(mem_rd),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .move_src_addr(move_src_addr),
    .third_pointer_out(third_pointer_out),
    .busy(busy)
  );
  xdec_prog_mem u_mem (.sel(sel), .lit(lit), .word(instr_word));
  initial forever #25 sys_clk = ~sys_clk;
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task op(input logic [2:0] k, input logic [5:0] fl);
    @(negedge sys_clk);
    sel = k;
    lit = r[11:0];
    working_register = r[19:12];
    instr_valid = 1'b1;
    if (fl[4])
      p2 = k == 3'h1 ? p2 + {6'h00, r[5:0]} : p2 - {6'h00, r[5:0]};
    if (fl[2] && k == 3'h0)
      p2 = p2 - 12'h001;
    if (fl != 6'h00)
      q.push_back({fl, p2});
    r = lfsr(r);
  endtask
  task tally_and_finish;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(negedge sys_clk)
  begin
    cyc++;
    got = {instr_taken, ret_req, call_req, mem_wr, mem_rd, illegal_instr, third_pointer_out};
    if (cyc > 1000)
    begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish;
    end
    else if (got[17:12] !== 6'h00)
    begin
      n_compared++;
      if (q.size() == 0 || got !== q.pop_front())
      begin
        failures++;
        $display("[FAIL] %0t result mismatch", $time);
      end
    end
  end
  initial
  begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      op(i[2:0], 6'h01);
    @(negedge sys_clk) instr_valid = 1'b0;
    extension_enable_bit = 1'b1;
    for (int i = 0; i < 60; i++)
    begin
      s = r[2:0] == 3'h5 ? 3'h4 : r[2:0];
      op(s, ft[s]);
      if (s == 3'h4)
        op(r[12] ? 3'h7 : 3'h5, r[12] ? 6'h01 : 6'h24);
      if (s inside {3'h1, 3'h2, 3'h3})
        @(negedge sys_clk) instr_valid = 1'b0;
    end
    @(negedge sys_clk) instr_valid = 1'b0;
    op(3'h4, 6'h22);
    @(negedge sys_clk) instr_valid = 1'b0;
    rst = 1'b1;
    @(negedge sys_clk) rst = 1'b0;
    p2 = 12'h000;
    op(3'h0, 6'h24);
    @(negedge sys_clk) instr_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    if (q.size() != 0)
    begin
      failures++;
      $display("[FAIL] %0t results missing", $time);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
